/* File: verilog/uolpc_top.sv */
// Purpose: data-line resistor, bus supply and module power control
// Assumes: one clock sys_clk at 25 MHz, synchronous active-low reset
// Notes: bus activity and hardware resistor requests arrive from pins
`timescale 1ns/100ps
`include "uolpc_defines.svh"

// Contract
// R1: line control bits 31..8 read zero; low byte read/write, resets zero.
// R2: bit 7 enables D+ pull-up, bit 6 enables D- pull-up.
// R3: bit 5 enables D+ pull-down, bit 4 enables D- pull-down.
// R4: ownership bit 2 set gives resistors to software, else hardware drives.
// R5: bit 3 drives the bus supply power output.
// R6: bit 1 enables charging the supply line through a pull-up.
// R7: bit 0 enables discharging the supply line through a pull-down.
// R8: activity pending reads one when activity seen, notification not yet given.
// R9: guard bit 4 blocks sleep while activity or notification pending.
// R10: busy reads one while active or disabled but not yet ready.
// R11: suspend bit gates the 48 MHz clock and idles the transceiver.
// R12: clearing enable holds outputs inactive and shuts analog features.
// R13: software avoids other registers while disabled and busy.
// R14: power bits 6,5,2 and 31..8 read zero; implemented bits reset zero.
// R15: writes to read-only or unimplemented bits change nothing.
module uolpc_top
   import uolpc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic bus_activity,
   input wire logic notify_sent,
   input wire logic [3:0] hw_resistor_req,
   output logic dplus_pullup_en,
   output logic dminus_pullup_en,
   output logic dplus_pulldown_en,
   output logic dminus_pulldown_en,
   output logic supply_power_on,
   output logic supply_charge_en,
   output logic supply_discharge_en,
   output logic usb_clk_gate_en,
   output logic xcvr_low_power,
   output logic pins_owned,
   output logic analog_en,
   output logic sleep_block
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] line;
      logic guard;
      logic suspend;
      logic enable;
      logic pending;
      uolpc_pwr_state_t pstate;
      logic [31:0] rdata;
      logic [3:0] res;
      logic [2:0] supply;
      logic clk_gate;
      logic low_pwr;
      logic owned;
      logic analog;
      logic sleep_blk;
   } uolpc_top_t;
   uolpc_top_t st;
   uolpc_top_t next_st;

   logic act_s;
   logic notify_s;
   logic [3:0] hw_req_s;
   logic settle_busy;
   logic settle_start;
   logic busy;
   logic [7:0] pwr_view;
   logic [3:0] res_sel;
   logic [7:0] line_w;

   // ----------------------------------------
   // pin inputs
   // ----------------------------------------
   uolpc_sync #(.WIDTH(6)) u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .async_in({bus_activity, notify_sent, hw_resistor_req}),
      .sync_out({act_s, notify_s, hw_req_s})
   );

   uolpc_settle u_settle (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .start(settle_start),
      .busy(settle_busy)
   );

   // ----------------------------------------
   // derived status
   // ----------------------------------------
   // disabling starts the settle count; re-enable waits for it
   assign settle_start = clk_en && st.pstate == UOLPC_ON && !st.enable;
   assign busy = st.pstate != UOLPC_OFF || settle_busy; // [R10]
   assign pwr_view = {st.pending, 2'b00, st.guard, busy, 1'b0, st.suspend, st.enable}; // [R14]
   assign line_w = st.line;

   always_comb begin
      next_st = st;
      res_sel = '0;
      if (clk_en) begin
         // --------------------------------
         // register writes
         // --------------------------------
         if (reg_wr && reg_addr == `UOLPC_OFS_LINE) begin
            next_st.line = reg_wdata[7:0]; // [R1]
         end
         if (reg_wr && reg_addr == `UOLPC_OFS_PWR) begin
            // only writable fields taken [R15]
            next_st.guard = reg_wdata[`UOLPC_PWR_GUARD];
            next_st.suspend = reg_wdata[`UOLPC_PWR_SUSP];
            next_st.enable = reg_wdata[`UOLPC_PWR_EN];
         end
         // --------------------------------
         // reads: data in the next cycle only
         // --------------------------------
         next_st.rdata = 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               `UOLPC_OFS_LINE: next_st.rdata = {24'h00_0000, line_w}; // [R1]
               `UOLPC_OFS_PWR: next_st.rdata = {24'h00_0000, pwr_view}; // [R14]
               default: next_st.rdata = 32'h0000_0000;
            endcase
         end
         // --------------------------------
         // activity pending: set wins over notification
         // --------------------------------
         if (act_s && st.enable) begin
            next_st.pending = 1'b1; // [R8]
         end else if (notify_s) begin
            next_st.pending = 1'b0; // [R8]
         end
         // --------------------------------
         // power sequence
         // --------------------------------
         case (st.pstate)
            UOLPC_OFF: if (st.enable && !settle_busy) next_st.pstate = UOLPC_ON;
            UOLPC_ON: if (!st.enable) next_st.pstate = UOLPC_SETTLE;
            UOLPC_SETTLE: if (!settle_busy) next_st.pstate = UOLPC_OFF;
            default: next_st.pstate = UOLPC_OFF;
         endcase
         // --------------------------------
         // outputs
         // --------------------------------
         if (line_w[`UOLPC_LINE_OWN]) begin
            res_sel = line_w[7:4]; // [R2] [R3] [R4]
         end else begin
            res_sel = hw_req_s; // [R4]
         end
         if (st.enable) begin
            next_st.res = res_sel;
            next_st.supply = line_w[`UOLPC_LINE_VON:`UOLPC_LINE_VON] == 1'b1 ?
               {1'b1, line_w[1:0]} : {1'b0, line_w[1:0]}; // [R5] [R6] [R7]
            next_st.clk_gate = !st.suspend; // [R11]
            next_st.low_pwr = st.suspend; // [R11]
            next_st.owned = 1'b1;
            next_st.analog = 1'b1;
         end else begin
            // disabled: everything inactive, transceiver held in low power [R12]
            next_st.res = 4'h0;
            next_st.supply = 3'h0;
            next_st.clk_gate = 1'b0;
            next_st.low_pwr = 1'b1;
            next_st.owned = 1'b0;
            next_st.analog = 1'b0;
         end
         next_st.sleep_blk = st.guard && (act_s || st.pending); // [R9]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign dplus_pullup_en = st.res[3];
   assign dminus_pullup_en = st.res[2];
   assign dplus_pulldown_en = st.res[1];
   assign dminus_pulldown_en = st.res[0];
   assign supply_power_on = st.supply[2];
   assign supply_charge_en = st.supply[1];
   assign supply_discharge_en = st.supply[0];
   assign usb_clk_gate_en = st.clk_gate;
   assign xcvr_low_power = st.low_pwr;
   assign pins_owned = st.owned;
   assign analog_en = st.analog;
   assign sleep_block = st.sleep_blk;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_line_read;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && reg_rd && reg_addr == `UOLPC_OFS_LINE |=> reg_rdata[31:8] == 24'h00_0000;
   endproperty
   a_line_read: assert property (p_line_read) else $error("line upper bits not zero"); // [R1]

   property p_pullup;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && st.enable && line_w[`UOLPC_LINE_OWN]
         |=> dplus_pullup_en == $past(line_w[7]) && dminus_pullup_en == $past(line_w[6]);
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up does not follow bits"); // [R2]

   property p_pulldown;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && st.enable && line_w[`UOLPC_LINE_OWN]
         |=> dplus_pulldown_en == $past(line_w[5]) && dminus_pulldown_en == $past(line_w[4]);
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("pull-down does not follow bits"); // [R3]

   property p_hw_own;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && st.enable && !line_w[`UOLPC_LINE_OWN]
         |=> {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en}
            == $past(hw_req_s);
   endproperty
   a_hw_own: assert property (p_hw_own) else $error("hardware ownership ignored"); // [R4]

   property p_supply;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && st.enable |=> supply_power_on == $past(line_w[3])
         && supply_charge_en == $past(line_w[1]) && supply_discharge_en == $past(line_w[0]);
   endproperty
   a_supply: assert property (p_supply) else $error("supply outputs wrong"); // [R5]

   property p_suspend;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && st.enable && st.suspend |=> !usb_clk_gate_en && xcvr_low_power;
   endproperty
   a_suspend: assert property (p_suspend) else $error("suspend did not gate clock"); // [R11]

   property p_disable;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && !st.enable |=> !pins_owned && !analog_en && !supply_power_on;
   endproperty
   a_disable: assert property (p_disable) else $error("disabled outputs active"); // [R12]

   property p_guard;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && !st.guard |=> !sleep_block;
   endproperty
   a_guard: assert property (p_guard) else $error("sleep blocked without guard"); // [R9]

   property p_pwr_read;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && reg_rd && reg_addr == `UOLPC_OFS_PWR
         |=> reg_rdata[6:5] == 2'b00 && reg_rdata[2] == 1'b0 && reg_rdata[3] == $past(busy);
   endproperty
   a_pwr_read: assert property (p_pwr_read) else $error("power register read wrong"); // [R14]

   property p_line_write;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && reg_wr && reg_addr == `UOLPC_OFS_LINE |=> st.line == $past(reg_wdata[7:0]);
   endproperty
   a_line_write: assert property (p_line_write) else $error("line write lost"); // [R1]

   property p_rdata_idle;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && !reg_rd |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot"); // [R1]

   property p_pending_set;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && act_s && st.enable |=> st.pending;
   endproperty
   a_pending_set: assert property (p_pending_set) else $error("pending not set"); // [R8]

   property p_pending_clear;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && notify_s && !(act_s && st.enable) |=> !st.pending;
   endproperty
   a_pending_clear: assert property (p_pending_clear) else $error("pending stuck"); // [R8]

   property p_guard_block;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && st.guard && st.pending |=> sleep_block;
   endproperty
   a_guard_block: assert property (p_guard_block) else $error("guard did not block"); // [R9]

   property p_busy_settle;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && st.pstate == UOLPC_ON && !st.enable |=> busy;
   endproperty
   a_busy_settle: assert property (p_busy_settle) else $error("busy low in settle"); // [R10]

   property p_stray_write;
      @(posedge sys_clk) disable iff (!resetn)
      clk_en && reg_wr && reg_addr != `UOLPC_OFS_LINE && reg_addr != `UOLPC_OFS_PWR
         |=> st.line == $past(st.line)
            && {st.guard, st.suspend, st.enable} == $past({st.guard, st.suspend, st.enable});
   endproperty
   a_stray_write: assert property (p_stray_write) else $error("stray write landed"); // [R15]

   c_enable: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(st.enable));
   c_settle: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(settle_busy));
   c_pending: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(st.pending));
   c_suspend: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(st.suspend));
endmodule

/* File: verilog/uolpc_defines.svh */
// Purpose: register offsets, field positions and reset values
// Assumes: 32-bit register port, word offsets
// Notes: offsets are local choices
`ifndef UOLPC_DEFINES_SVH
`define UOLPC_DEFINES_SVH
`define UOLPC_OFS_LINE 8'h00
`define UOLPC_OFS_PWR 8'h04
`define UOLPC_LINE_RESET 8'h00
`define UOLPC_PWR_RESET 8'h00
`define UOLPC_LINE_DPPU 7
`define UOLPC_LINE_DMPU 6
`define UOLPC_LINE_DPPD 5
`define UOLPC_LINE_DMPD 4
`define UOLPC_LINE_VON 3
`define UOLPC_LINE_OWN 2
`define UOLPC_LINE_CHG 1
`define UOLPC_LINE_DIS 0
`define UOLPC_PWR_ACT 7
`define UOLPC_PWR_GUARD 4
`define UOLPC_PWR_BUSY 3
`define UOLPC_PWR_SUSP 1
`define UOLPC_PWR_EN 0
`define UOLPC_PWR_WMASK 8'h13
`define UOLPC_SETTLE_NS 200
`define UOLPC_CLK_NS 40
`define UOLPC_SETTLE_CYC ((`UOLPC_SETTLE_NS + `UOLPC_CLK_NS - 1) / `UOLPC_CLK_NS)
`endif

/* File: verilog/uolpc_pkg.sv */
// Purpose: shared types of the line and power control block
// Assumes: nothing
// Notes: constants live in uolpc_defines.svh
package uolpc_pkg;
   typedef enum logic [1:0] {
      UOLPC_OFF,
      UOLPC_ON,
      UOLPC_SETTLE
   } uolpc_pwr_state_t;
endpackage

/* File: verilog/uolpc_sync.sv */
// Purpose: two-flop synchroniser for pin-level inputs
// Assumes: single clock sys_clk
// Notes: first stage read only by the second
`timescale 1ns/100ps
module uolpc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } uolpc_sync_t;
   uolpc_sync_t st;
   uolpc_sync_t next_st;

   always_comb begin
      next_st = st;
      if (clk_en) begin
         next_st.meta = async_in;
         next_st.sync = st.meta;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.sync;
endmodule

/* File: verilog/uolpc_settle.sv */
// Purpose: counts settle time after the module is disabled
// Assumes: start is a one-cycle pulse
// Notes: busy high from start until the count runs out
`timescale 1ns/100ps
`include "uolpc_defines.svh"
module uolpc_settle (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic start,
   output logic busy
);
   typedef struct packed {
      logic [7:0] cnt;
      logic busy;
   } uolpc_settle_t;
   uolpc_settle_t st;
   uolpc_settle_t next_st;

   always_comb begin
      next_st = st;
      if (clk_en) begin
         if (start) begin
            next_st.cnt = 8'(`UOLPC_SETTLE_CYC);
            next_st.busy = 1'b1;
         end else if (st.cnt > 8'h01) begin
            next_st.cnt = st.cnt - 8'h01;
         end else begin
            next_st.cnt = 8'h00;
            next_st.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign busy = st.busy;
endmodule

/* File: tb/uolpc_cable_model.sv */
// Purpose: far side of the cable: activity bursts and hardware resistor requests
// Assumes: burst is a one-cycle request from the bench
// Notes: activity is a short level burst, then the wire goes quiet
`timescale 1ns/100ps
module uolpc_cable_model (
   input wire logic sys_clk,
   input wire logic burst,
   input wire logic [3:0] hw_pattern,
   output logic bus_activity,
   output logic [3:0] hw_resistor_req
);
   logic [3:0] left;
   // ---------------
   // wire behaviour
   // ---------------
   initial left = 4'h0;
   always @(posedge sys_clk) begin
      if (burst) begin
         left <= 4'h6;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
      hw_resistor_req <= hw_pattern;
   end
   assign bus_activity = (left != 4'h0);
endmodule

/* File: tb/uolpc_top_tb.sv */
// Purpose: self-checking bench of the line and power control block
// Assumes: 25 MHz sys_clk, register port with read data one cycle late
// Notes: waits are bounded; a watchdog ends a hung run
`timescale 1ns/100ps
`include "uolpc_defines.svh"
module uolpc_top_tb;
   import uolpc_pkg::*;
   logic sys_clk, resetn, clk_en, reg_wr, reg_rd, notify_sent, burst, bus_activity;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [3:0] hw_pattern, hw_resistor_req;
   logic dpu, dmu, dpd, dmd, von, chg, dis, gate, lowp, owned, analog, sleep_block;
   logic [7:0] line_outs;
   int error_cnt = 0;
   int samples_checked = 0;
   assign line_outs = {dpu, dmu, dpd, dmd, von, 1'b0, chg, dis};
   uolpc_top i_uolpc_top (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .bus_activity(bus_activity), .notify_sent(notify_sent),
      .hw_resistor_req(hw_resistor_req), .dplus_pullup_en(dpu), .dminus_pullup_en(dmu),
      .dplus_pulldown_en(dpd), .dminus_pulldown_en(dmd), .supply_power_on(von),
      .supply_charge_en(chg), .supply_discharge_en(dis), .usb_clk_gate_en(gate),
      .xcvr_low_power(lowp), .pins_owned(owned), .analog_en(analog),
      .sleep_block(sleep_block));
   uolpc_cable_model i_uolpc_cable_model (.sys_clk(sys_clk), .burst(burst),
      .hw_pattern(hw_pattern), .bus_activity(bus_activity),
      .hw_resistor_req(hw_resistor_req));
   // ---------------
   // helpers
   // ---------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, w, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      // data stand for this one cycle only
      @(negedge sys_clk);
      v = reg_rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string w);
      logic [31:0] v;
      rd(a, v);
      chk(v, e, w);
   endtask
   task automatic pulse_notify();
      notify_sent <= 1'b1;
      cyc(3);
      notify_sent <= 1'b0;
      cyc(4);
   endtask
   // ---------------
   // scenarios
   // ---------------
   task automatic t_reset();
      rc(`UOLPC_OFS_LINE, 32'h0, "line reset");
      rc(`UOLPC_OFS_PWR, 32'h0, "power reset");
      chk({24'h0, line_outs}, 32'h0, "line outputs at reset");
      chk({29'h0, gate, owned, analog}, 32'h0, "power outputs at reset");
      $display("test reset done");
   endtask
   task automatic t_line();
      logic [7:0] v;
      wr(`UOLPC_OFS_PWR, 32'h1);
      for (int b = 0; b < 8; b++) begin
         v = 8'h04 | (8'h01 << b);
         wr(`UOLPC_OFS_LINE, {24'hFFFFFF, v});
         rc(`UOLPC_OFS_LINE, {24'h0, v}, "line readback");
         cyc(2);
         chk({24'h0, line_outs}, {24'h0, v & 8'hFB}, "line outputs");
      end
      $display("test line done");
   endtask
   task automatic t_hw();
      hw_pattern <= 4'hA;
      wr(`UOLPC_OFS_LINE, 32'h0);
      cyc(6);
      chk({24'h0, line_outs}, 32'hA0, "hardware owned resistors");
      hw_pattern <= 4'h5;
      wr(`UOLPC_OFS_LINE, 32'hF8);
      cyc(6);
      chk({24'h0, line_outs}, 32'h58, "software bits ignored");
      $display("test hw done");
   endtask
   task automatic t_pwr();
      wr(`UOLPC_OFS_PWR, 32'hFFFFFFFF);
      rc(`UOLPC_OFS_PWR, 32'h1B, "power write all");
      cyc(2);
      chk({30'h0, gate, lowp}, 32'h1, "suspended");
      wr(`UOLPC_OFS_PWR, 32'h1);
      rc(`UOLPC_OFS_PWR, 32'h09, "power resumed");
      cyc(2);
      chk({30'h0, gate, lowp}, 32'h2, "running");
      $display("test power done");
   endtask
   task automatic t_act();
      wr(`UOLPC_OFS_PWR, 32'h11);
      burst <= 1'b1;
      cyc(1);
      burst <= 1'b0;
      cyc(5);
      chk({31'h0, sleep_block}, 32'h1, "guard blocks on activity");
      rc(`UOLPC_OFS_PWR, 32'h99, "activity pending");
      cyc(8);
      chk({31'h0, sleep_block}, 32'h1, "guard blocks on pending");
      pulse_notify();
      rc(`UOLPC_OFS_PWR, 32'h19, "pending cleared");
      chk({31'h0, sleep_block}, 32'h0, "guard released");
      wr(`UOLPC_OFS_PWR, 32'h1);
      burst <= 1'b1;
      cyc(1);
      burst <= 1'b0;
      cyc(5);
      chk({31'h0, sleep_block}, 32'h0, "no guard no block");
      pulse_notify();
      $display("test activity done");
   endtask
   task automatic t_off();
      logic [31:0] v;
      int n;
      wr(`UOLPC_OFS_LINE, 32'hFF);
      wr(`UOLPC_OFS_PWR, 32'h0);
      rd(`UOLPC_OFS_PWR, v);
      chk(v & 32'h08, 32'h08, "busy while settling");
      n = 0;
      // only the power register is touched until the module is ready
      while (v[`UOLPC_PWR_BUSY] !== 1'b0 && n < 20) begin
         rd(`UOLPC_OFS_PWR, v);
         n++;
      end
      if (v[`UOLPC_PWR_BUSY] !== 1'b0) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: busy never cleared", $time);
         end_of_test();
      end
      chk(v, 32'h0, "ready after settle");
      chk({24'h0, line_outs}, 32'h0, "outputs held inactive");
      chk({29'h0, gate, owned, analog}, 32'h0, "pins and analog released");
      $display("test disable done");
   endtask
   task automatic t_unmapped();
      rc(8'h08, 32'h0, "unmapped read");
      wr(8'h08, 32'hFFFFFFFF);
      rc(`UOLPC_OFS_LINE, 32'hFF, "line untouched");
      rc(`UOLPC_OFS_PWR, 32'h0, "power untouched");
      clk_en <= 1'b0;
      wr(`UOLPC_OFS_LINE, 32'h0);
      clk_en <= 1'b1;
      rc(`UOLPC_OFS_LINE, 32'hFF, "frozen write ignored");
      $display("test unmapped done");
   endtask
   task automatic t_rerst();
      wr(`UOLPC_OFS_PWR, 32'h13);
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      rc(`UOLPC_OFS_LINE, 32'h0, "line after second reset");
      rc(`UOLPC_OFS_PWR, 32'h0, "power after second reset");
      chk({24'h0, line_outs}, 32'h0, "line outputs after second reset");
      $display("test second reset done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ---------------
   // run
   // ---------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_of_test();
   end
   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      notify_sent = 1'b0;
      burst = 1'b0;
      hw_pattern = 4'h0;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset();
      t_line();
      t_hw();
      t_pwr();
      t_act();
      t_off();
      t_unmapped();
      t_rerst();
      end_of_test();
   end
endmodule
